// ### bench/shp_host_model.sv
`timescale 1ns/100ps
module shp_host_model (
    // Clock
    input wire logic clk,
    // Device answer
    input wire logic cycle_stretch_n,
    input wire logic [15:0] host_data_bus_out,
    input wire logic host_data_bus_oe,
    // Host pins
    output logic host_chip_select_n,
    output logic host_write_strobe_n,
    output logic host_read_strobe_n,
    output logic upper_byte_enable_n,
    output logic lower_byte_enable_n,
    output logic [23:1] host_address_bus,
    output logic [15:0] host_data_bus_in
);
    logic drv;
    logic [15:0] wd;
    logic [15:0] last;

    initial begin
        {host_chip_select_n, host_write_strobe_n, host_read_strobe_n} = 3'h7;
        {upper_byte_enable_n, lower_byte_enable_n} = 2'h3;
        host_address_bus = 23'h000000;
        drv = 1'b0;
        wd = 16'h0000;
        last = 16'h0000;
    end

    // No pull on the bus: a released bus shows the inverse of its last value
    assign host_data_bus_in = host_data_bus_oe ? host_data_bus_out : (drv ? wd : ~last);
    always @(negedge clk) if (drv || host_data_bus_oe) last <= host_data_bus_in;

    task access(input logic w, input logic [23:1] a, input logic [15:0] d,
                output logic [15:0] q, output logic st, output logic an);
        int n;
        @(negedge clk);
        host_address_bus <= a;
        host_chip_select_n <= 1'b0;
        upper_byte_enable_n <= a[1];
        lower_byte_enable_n <= ~a[1];
        wd <= d;
        drv <= w;
        repeat (2) @(negedge clk);
        if (w) host_write_strobe_n <= 1'b0;
        else host_read_strobe_n <= 1'b0;
        @(negedge clk);
        st = !cycle_stretch_n;
        n = 0;
        while (!cycle_stretch_n && n < 200) begin
            @(negedge clk);
            n++;
        end
        // Strobe kept one cycle past the release, as a slow host does
        @(negedge clk);
        an = cycle_stretch_n && st;
        q = host_data_bus_in;
        host_write_strobe_n <= 1'b1;
        host_read_strobe_n <= 1'b1;
        repeat (2) @(negedge clk);
        host_chip_select_n <= 1'b1;
        drv <= 1'b0;
        repeat (2) @(negedge clk);
    endtask : access
endmodule : shp_host_model

// ### bench/testbench.sv
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fails++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module testbench;
    import shp_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, stretch_n, oe, trap_done, req_valid, req_ready = 1'b0;
    logic ube_n, lbe_n, cs_n, wr_n, rd_n, st, an;
    logic clk_en = 1'b1;
    logic [23:1] addr;
    logic [15:0] din, dout, q, rsp_rdata = 16'h0000;
    logic [2:0] variant;
    shp_mode_e mode;
    shp_strap_s straps = 5'h00;
    shp_req_s req, last_req;
    int fails = 0, checks_done = 0, cycles = 0, lat = 0, wait_n = 0, nreq = 0, n0 = 0;
    logic [4:0] tbl [6] = '{5'h04, 5'h1A, 5'h10, 5'h08, 5'h01, 5'h00};
    shp_mode_e em [6] = '{SHP_MODE_OTHER, SHP_MODE_OTHER, SHP_MODE_IND16, SHP_MODE_IND8,
                          SHP_MODE_DIRECT16, SHP_MODE_DIRECT16};

    initial forever #10 clk = ~clk;

    shp_host_port i_shp_host_port (.clk(clk), .clk_en(clk_en), .rst_n(rst_n),
        .host_chip_select_n(cs_n), .host_write_strobe_n(wr_n), .host_read_strobe_n(rd_n),
        .upper_byte_enable_n(ube_n), .lower_byte_enable_n(lbe_n), .cycle_stretch_n(stretch_n),
        .host_address_bus(addr), .host_data_bus_in(din), .host_data_bus_out(dout),
        .host_data_bus_oe(oe), .straps(straps), .protocol_variant(variant), .protocol_mode(mode),
        .trap_done(trap_done), .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .rsp_rdata(rsp_rdata));
    shp_host_model i_shp_host_model (.clk(clk), .cycle_stretch_n(stretch_n),
        .host_data_bus_out(dout), .host_data_bus_oe(oe), .host_chip_select_n(cs_n),
        .host_write_strobe_n(wr_n), .host_read_strobe_n(rd_n), .upper_byte_enable_n(ube_n),
        .lower_byte_enable_n(lbe_n), .host_address_bus(addr), .host_data_bus_in(din));

    // Internal side answers after lat cycles; read data derived from the address
    always @(negedge clk) begin
        req_ready <= 1'b0;
        if (req_valid && !req_ready) begin
            if (wait_n >= lat) begin
                req_ready <= 1'b1;
                rsp_rdata <= req.addr[16:1] ^ 16'hA5C3;
                last_req <= req;
                nreq++;
                wait_n <= 0;
            end else wait_n <= wait_n + 1;
        end
    end

    task end_of_test;
        if (fails == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            end_of_test;
        end
    end

    task do_reset(input logic [4:0] s);
        @(negedge clk);
        straps = s;
        rst_n = 1'b0;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
    endtask : do_reset

    task wr(input logic [23:1] a, input logic [15:0] d);
        i_shp_host_model.access(1'b1, a, d, q, st, an);
        `CHK(st, 1'b1)
        `CHK(an, 1'b1)
        `CHK(last_req, {1'b1, a[23], a, 1'b0, d})
    endtask : wr

    task rd(input logic [23:1] a);
        i_shp_host_model.access(1'b0, a, 16'h0000, q, st, an);
        `CHK(an, 1'b1)
        `CHK(last_req.addr, {a, 1'b0})
        `CHK(last_req.to_mem, a[23])
        `CHK(q, a[16:1] ^ 16'hA5C3)
    endtask : rd

    initial begin
        for (int i = 0; i < 6; i++) begin
            do_reset(tbl[i]);
            `CHK(trap_done, 1'b1)
            `CHK(variant, {tbl[i][3], tbl[i][4], |tbl[i][2:0]})
            `CHK(mode, em[i])
            lat = nreq;
            i_shp_host_model.access(1'b1, 23'h000123, 16'h5A5A, q, st, an);
            `CHK(st, em[i] == SHP_MODE_DIRECT16)
            `CHK(nreq - lat, int'(em[i] == SHP_MODE_DIRECT16))
        end
        for (int j = 0; j < 2; j++) begin
            lat = j * 5;
            wr(j ? 23'h400000 : 23'h3FFFFF, 16'hC0DE ^ 16'(j));
            rd(j ? 23'h7FFFFF : 23'h000001);
        end
        // Frozen port must not start the request until enabled
        clk_en = 1'b0;
        n0 = nreq;
        fork
            i_shp_host_model.access(1'b1, 23'h654321, 16'h1234, q, st, an);
        join_none
        repeat (8) @(negedge clk);
        `CHK({stretch_n, req_valid}, 2'h0)
        `CHK(nreq - n0, 0)
        clk_en = 1'b1;
        wait fork;
        `CHK(an, 1'b1)
        `CHK(last_req, {1'b1, 1'b1, 23'h654321, 1'b0, 16'h1234})
        lat = 100;
        fork
            i_shp_host_model.access(1'b0, 23'h412345, 16'h0000, q, st, an);
        join_none
        repeat (6) @(negedge clk);
        #5 rst_n = 1'b0;
        #1;
        `CHK(stretch_n, 1'b1)
        `CHK({req_valid, oe, trap_done}, 3'h0)
        wait fork;
        lat = 0;
        do_reset(5'h00);
        rd(23'h400002);
        end_of_test;
    end
endmodule : testbench

// ### rtl/shp_consts.svh
// Overview of operation
// RULE_01 - Only single accesses are served; page and burst transfers are not supported.
// RULE_02 - A 24-bit byte address is decoded; pins carry bits 23 down to 1.
// RULE_03 - The lower 8MB reaches configuration registers; the upper 8MB reaches frame memory.
// RULE_04 - Direct 16-bit, indirect 8-bit and indirect 16-bit modes exist as protocol variants.
// RULE_05 - One of eight variants is chosen at trapping from five strap inputs.
// RULE_06 - The board holds both configuration straps, address-valid and bus-clock straps low.
// RULE_07 - Direct mode uses separate address and data; each cycle moves one 16-bit word.
// RULE_08 - Separate active-low read and write strobes control the cycle direction.
// RULE_09 - A falling read or write strobe drives the stretch output low.
// RULE_10 - The host keeps the cycle open while the stretch signal is low.
// RULE_11 - The host enables wait handling on the chip-select bank used here.
// RULE_12 - The host sets address and chip select 30 ns before the strobe.
// RULE_13 - Without wait handling, the write strobe stays active for 150 ns.
// RULE_14 - Without wait handling, the read strobe stays active for 280 ns.
// RULE_15 - The host holds address 30 ns after the strobe, then 30 ns turnaround.
// RULE_16 - Byte-enable inputs are ignored in the direct read and write cycles.
// RULE_17 - The chip reset acts asynchronously and resets the whole port.
// RULE_18 - The reference clock comes from the oscillator input at 32K or 13MHz.
// RULE_19 - Stretch is released only when write data is taken or read data is valid.
`ifndef SHP_CONSTS_SVH
`define SHP_CONSTS_SVH

`define SHP_ADDR_W 24
`define SHP_DATA_W 16
`define SHP_REGION_BIT 23
`define SHP_VARIANT_W 3
`define SHP_RDATA_RST 16'h0000
`define SHP_CLK_PERIOD_NS 20
`define SHP_HOLD_NS 30
`define SHP_HOLD_CYC (((`SHP_HOLD_NS) + (`SHP_CLK_PERIOD_NS) - 1) / (`SHP_CLK_PERIOD_NS))

`endif

// ### rtl/shp_host_port.sv
`timescale 1ns/100ps
`include "shp_consts.svh"

module shp_host_port
    import shp_pkg::*;
(
    // Clock from the oscillator path, enable, chip reset
    input wire logic clk,
    input wire logic clk_en,
    input wire logic rst_n,
    // Host strobes
    input wire logic host_chip_select_n,
    input wire logic host_write_strobe_n,
    input wire logic host_read_strobe_n,
    input wire logic upper_byte_enable_n,
    input wire logic lower_byte_enable_n,
    output logic cycle_stretch_n,
    // Host address and data
    input wire logic [23:1] host_address_bus,
    input wire logic [15:0] host_data_bus_in,
    output logic [15:0] host_data_bus_out,
    output logic host_data_bus_oe,
    // Straps sampled at trapping
    input wire shp_strap_s straps,
    // Decoded protocol variant
    output logic [2:0] protocol_variant,
    output shp_mode_e protocol_mode,
    output logic trap_done,
    // Internal request side
    output logic req_valid,
    output shp_req_s req,
    input wire logic req_ready,
    input wire logic [15:0] rsp_rdata
);

    shp_state_s s_reg;
    shp_state_s s_next;
    logic strobe_low;
    logic cs_low;
    logic direct;
    logic fall;

    // RULE_05 variant map
    function automatic logic [2:0] shp_variant(input shp_strap_s st);
        shp_variant = {st.protocol_strap_one, st.protocol_strap_zero,
                       st.bus_clock_strap | st.address_valid_strap | st.address_bit_ten_strap};
    endfunction : shp_variant

    // RULE_04 mode from straps
    function automatic shp_mode_e shp_mode(input shp_strap_s st);
        if (!st.protocol_strap_one && !st.protocol_strap_zero) begin
            // RULE_06 all four low selects 80-type direct
            if (!st.bus_clock_strap && !st.address_valid_strap) begin
                shp_mode = SHP_MODE_DIRECT16;
            end else begin
                shp_mode = SHP_MODE_OTHER;
            end
        end else if (!st.protocol_strap_one) begin
            shp_mode = SHP_MODE_IND16;
        end else if (!st.protocol_strap_zero) begin
            shp_mode = SHP_MODE_IND8;
        end else begin
            shp_mode = SHP_MODE_OTHER;
        end
    endfunction : shp_mode

    assign cs_low = !host_chip_select_n;
    // RULE_08 separate strobes, no direction pin
    assign strobe_low = !host_write_strobe_n || !host_read_strobe_n;
    // Indirect variants are not served; the port stays idle in them
    assign direct = s_reg.trapped && (s_reg.mode == SHP_MODE_DIRECT16);
    assign fall = direct && cs_low && strobe_low && (s_reg.state == SHP_ST_IDLE);

    always_comb begin
        s_next = s_reg;
        if (!s_reg.trapped) begin
            // RULE_05 one-shot trapping after reset release
            s_next.trapped = 1'b1;
            s_next.variant = shp_variant(straps);
            s_next.mode = shp_mode(straps);
        end
        case (s_reg.state)
            SHP_ST_IDLE: begin
                if (fall) begin
                    // RULE_02 byte address with bit zero implied
                    s_next.req.addr = {host_address_bus, 1'b0};
                    // RULE_03 top bit splits registers from frame memory
                    s_next.req.to_mem = host_address_bus[`SHP_REGION_BIT];
                    s_next.req.write = !host_write_strobe_n;
                    // RULE_07 one full word per cycle
                    s_next.req.wdata = host_data_bus_in;
                    s_next.is_write = !host_write_strobe_n;
                    s_next.req_valid = 1'b1;
                    s_next.state = SHP_ST_ACCESS;
                end
            end
            SHP_ST_ACCESS: begin
                if (req_ready) begin
                    s_next.req_valid = 1'b0;
                    if (!s_reg.is_write) begin
                        s_next.rdata = rsp_rdata;
                    end
                    s_next.state = SHP_ST_DONE;
                end
            end
            SHP_ST_DONE: begin
                // RULE_01 one access per strobe, no bursts
                if (!strobe_low || !cs_low) begin
                    s_next.state = SHP_ST_IDLE;
                end
            end
            default: begin
                s_next.state = SHP_ST_IDLE;
            end
        endcase
        if (!clk_en) begin
            s_next = s_reg;
        end
    end

    // RULE_17 chip reset acts without the clock
    // Asynchronous so a stopped oscillator cannot hold off reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '{state: SHP_ST_IDLE, mode: SHP_MODE_OTHER, variant: 3'h0, trapped: 1'b0,
                       req_valid: 1'b0, req: '0, rdata: `SHP_RDATA_RST, is_write: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    // RULE_09 stretch from the strobe edge onward
    // RULE_19 released only once the word is taken or read data is out
    // Combinational so wait shows in the strobe's own cycle; costs a pin-to-pin path
    assign cycle_stretch_n = !(direct && cs_low && strobe_low && (s_reg.state != SHP_ST_DONE));

    // RULE_16 byte enables do not enter any decode
    assign host_data_bus_out = s_reg.rdata;
    assign host_data_bus_oe = direct && cs_low && !host_read_strobe_n && (s_reg.state == SHP_ST_DONE)
                              && !s_reg.is_write;

    assign protocol_variant = s_reg.variant;
    assign protocol_mode = s_reg.mode;
    assign trap_done = s_reg.trapped;
    assign req_valid = s_reg.req_valid;
    assign req = s_reg.req;

    // RULE_18 clock period used for derived counts
    localparam int HOLD_CYC = `SHP_HOLD_CYC;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence strobe_edge_s;
        clk_en && fall;
    endsequence

    sequence taken_s;
        clk_en && req_valid && req_ready;
    endsequence

    // Strobe or select seen high while the word is finished
    sequence done_release_s;
        clk_en && (s_reg.state == SHP_ST_DONE) && !(strobe_low && cs_low);
    endsequence

    sequence write_edge_s;
        clk_en && fall && !host_write_strobe_n;
    endsequence

    // A frozen edge may hide a strobe rise, so such edges are left out
    stretch_on_strobe_a: assert property ( // RULE_09
        direct && cs_low && $past(clk_en) && $fell(host_write_strobe_n && host_read_strobe_n) |-> !cycle_stretch_n)
        else $error("stretch not driven low on strobe fall");

    stretch_idle_a: assert property (!cs_low |-> cycle_stretch_n) // RULE_09
        else $error("stretch low without chip select");

    request_follows_a: assert property (strobe_edge_s |=> req_valid) // RULE_07
        else $error("no request after strobe fall");

    addr_capture_a: assert property ( // RULE_02
        strobe_edge_s |=> (req.addr[23:1] == $past(host_address_bus)))
        else $error("request address differs from pins");

    wdata_capture_a: assert property ( // RULE_07
        write_edge_s |=> req.write && (req.wdata == $past(host_data_bus_in)))
        else $error("write word not captured at strobe fall");

    busy_stretch_a: assert property (req_valid && cs_low && strobe_low |-> !cycle_stretch_n) // RULE_19
        else $error("stretch released while request open");

    release_after_take_a: assert property (taken_s ##1 (cs_low && strobe_low) |-> cycle_stretch_n) // RULE_19
        else $error("stretch not released after access taken");

    held_until_taken_a: assert property (req_valid && !req_ready |=> req_valid && $stable(req)) // RULE_19
        else $error("request dropped before taken");

    read_data_match_a: assert property ( // RULE_19
        (taken_s and !req.write) |=> (host_data_bus_out == $past(rsp_rdata)))
        else $error("read data not latched");

    region_split_a: assert property (req_valid |-> req.to_mem == req.addr[`SHP_REGION_BIT]) // RULE_03
        else $error("region decode wrong");

    even_address_a: assert property (req_valid |-> req.addr[0] == 1'b0) // RULE_02
        else $error("byte address bit zero set");

    write_no_drive_a: assert property (req.write && (s_reg.state == SHP_ST_DONE) |-> !host_data_bus_oe) // RULE_08
        else $error("bus driven on a write");

    data_hold_a: assert property ( // RULE_08
        host_data_bus_oe |-> cs_low && !host_read_strobe_n && !s_reg.is_write)
        else $error("bus driven outside a read strobe");

    refused_mode_a: assert property ( // RULE_04
        trap_done && (protocol_mode != SHP_MODE_DIRECT16) |-> !req_valid && cycle_stretch_n && !host_data_bus_oe)
        else $error("port active in an unserved variant");

    single_access_a: assert property (taken_s ##1 (clk_en && strobe_low && cs_low) |=> !req_valid) // RULE_01
        else $error("second request within one strobe");

    trap_once_a: assert property (trap_done |=> trap_done && $stable(protocol_variant)) // RULE_05
        else $error("variant changed after trapping");

    // Port must be idle again before the host's hold time runs out
    idle_in_hold_a: assert property (done_release_s |-> ##[1:HOLD_CYC] (s_reg.state == SHP_ST_IDLE)) // RULE_15
        else $error("port not idle after strobe release");

endmodule : shp_host_port

// ### rtl/shp_pkg.sv
package shp_pkg;

    typedef enum logic [1:0] {
        SHP_ST_IDLE,
        SHP_ST_ACCESS,
        SHP_ST_DONE
    } shp_state_e;

    typedef enum logic [1:0] {
        SHP_MODE_DIRECT16,
        SHP_MODE_IND16,
        SHP_MODE_IND8,
        SHP_MODE_OTHER
    } shp_mode_e;

    typedef struct packed {
        logic write;
        logic to_mem;
        logic [23:0] addr;
        logic [15:0] wdata;
    } shp_req_s;

    typedef struct packed {
        logic protocol_strap_zero;
        logic protocol_strap_one;
        logic bus_clock_strap;
        logic address_valid_strap;
        logic address_bit_ten_strap;
    } shp_strap_s;

    typedef struct packed {
        shp_state_e state;
        shp_mode_e mode;
        logic [2:0] variant;
        logic trapped;
        logic req_valid;
        shp_req_s req;
        logic [15:0] rdata;
        logic is_write;
    } shp_state_s;

endpackage : shp_pkg
